//--- verilog/wake_bank_pkg.sv
// package: register map, field layout and carriers of the wake-enable bank
package wake_bank_pkg;

  // ---------------------------------------------------------------
  // register indices (printed offsets) and byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0]  IDX_ENABLE_GROUP3 = 8'h0c;      // group-3 enable
  localparam logic [7:0]  IDX_ENABLE_GROUP4 = 8'h0d;      // group-4 enable
  localparam logic [11:0] ADDR_ENABLE_GROUP3 = {2'b00, IDX_ENABLE_GROUP3, 2'b00};
  localparam logic [11:0] ADDR_ENABLE_GROUP4 = {2'b00, IDX_ENABLE_GROUP4, 2'b00};
  localparam logic [11:0] ADDR_IRQ_STATUS   = 12'h040;    // sticky events
  localparam logic [11:0] ADDR_IRQ_MASK     = 12'h044;    // event mask
  localparam logic [11:0] ADDR_WAKE_STATE   = 12'h048;    // gated sources

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  ENABLE_RESET      = 8'h00;      // standby POR only
  localparam logic [2:0]  IRQ_RESET         = 3'h0;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int          G3_DEVICE_IRQ_BIT = 3;          // grouped SMI
  localparam int          EVT_WAKE_SET      = 0;          // request rose
  localparam int          EVT_WAKE_CLR      = 1;          // request fell
  localparam int          EVT_MAIN_RESET    = 2;          // main-side reset
  localparam int          EVT_W             = 3;
  localparam int          RST_PINS_W        = 3;          // main/soft/hard

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  // group-3 bits: 0-2 gpio_2_0..2, 3 grouped SMI, 4-7 gpio_2_4..7
  // group-4 bits: 0-3 gpio_3_0..3, 4 gpio_4_1, 5 gpio_4_3,
  //               6 gpio_6_0, 7 gpio_6_1
  typedef struct packed {
    logic [7:0] grp4;                                     // group-4 lane
    logic [7:0] grp3;                                     // group-3 lane
  } wake_src_t;

  // register selector from the decoded address
  typedef enum {
    SEL_NONE,
    SEL_EN3,
    SEL_EN4,
    SEL_STATUS,
    SEL_MASK,
    SEL_STATE
  } reg_sel_t;

  // apb answer carrier
  typedef struct packed {
    logic [31:0] rdata;                                   // read data
    logic        ready;                                   // transfer end
    logic        slverr;                                  // unmapped
  } apb_rsp_t;

endpackage

//--- verilog/sync_two_flop.sv
// two flip-flop synchroniser for asynchronous level inputs
`timescale 1ns/1ps

module sync_two_flop #(
  parameter int WIDTH = 1                    // number of levels
) (
  input  wire logic             pclk,        // block clock
  input  wire logic             presetn,     // async reset, active low
  input  wire logic [WIDTH-1:0] async_in,    // raw pin levels
  output logic      [WIDTH-1:0] sync_out     // levels in pclk domain
);

  // ---------------------------------------------------------------
  // synchroniser stages
  // ---------------------------------------------------------------
  logic [WIDTH-1:0] meta_r;                  // first stage, read only below

  // first stage feeds second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

//--- verilog/wake_gate.sv
// per-source gating of wake status into one combined wake request
`timescale 1ns/1ps

module wake_gate #(
  parameter int WIDTH = 16                   // number of wake sources
) (
  input  wire logic             pclk,        // block clock
  input  wire logic             presetn,     // async reset, active low
  input  wire logic [WIDTH-1:0] status,      // wake status bits
  input  wire logic [WIDTH-1:0] enable,      // wake enable bits
  input  wire logic             global_en,   // global wake enable
  output logic      [WIDTH-1:0] gated,       // enabled and pending
  output logic                  wake_req     // registered combined request
);

  // ---------------------------------------------------------------
  // per-source gate
  // ---------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_src
      assign gated[i] = status[i] & enable[i];
    end
  endgenerate

  // ---------------------------------------------------------------
  // combined request
  // ---------------------------------------------------------------
  // or of sources, global gate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= global_en & (|gated);
    end
  end

endmodule

//--- verilog/wake_enable_bank.sv
// wake-enable registers for groups 3 and 4 with apb access and wake drive
//
// Chosen here: the APB register port.
`timescale 1ns/1ps

// Behaviour
// - wake only when enable, status, global set
// - disabled source shows no status in wake state, no wake
// - enables cleared by standby reset only
// - group-3 bit map, bit 3 grouped SMI
// - group-3 bit 3 lets grouped SMI wake
// - group-4 bit map of gpio ports
module wake_enable_bank (
  input  wire logic        pclk,              // apb clock, 40 MHz
  input  wire logic        presetn,           // standby-supply power-on reset
  input  wire logic        psel,              // apb select
  input  wire logic        penable,           // apb access phase
  input  wire logic        pwrite,            // apb direction
  input  wire logic [11:0] paddr,             // apb byte address
  input  wire logic [31:0] pwdata,            // apb write data
  output logic      [31:0] prdata,            // apb read data
  output logic             pready,            // apb ready
  output logic             pslverr,           // apb error
  input  wire logic [7:0]  wake_status_grp3,  // status, group 3 sources
  input  wire logic [7:0]  wake_status_grp4,  // status, group 4 sources
  input  wire logic        global_wake_enable, // global gate
  input  wire logic        main_por_n,        // main-supply reset pin
  input  wire logic        soft_reset,        // soft reset pin
  input  wire logic        hard_reset,        // hard reset pin
  output logic             wake_request_n_o,  // open-drain data, low = wake
  output logic             wake_request_n_oe, // high while pulling low
  output logic             irq                // level interrupt
);

  // ---------------------------------------------------------------
  // decode function
  // ---------------------------------------------------------------
  // maps a byte address to a register selector
  function automatic wake_bank_pkg::reg_sel_t decode(input logic [11:0] a);
    wake_bank_pkg::reg_sel_t s;
    s = wake_bank_pkg::SEL_NONE;
    case (a)
      wake_bank_pkg::ADDR_ENABLE_GROUP3: s = wake_bank_pkg::SEL_EN3;
      wake_bank_pkg::ADDR_ENABLE_GROUP4: s = wake_bank_pkg::SEL_EN4;
      wake_bank_pkg::ADDR_IRQ_STATUS:    s = wake_bank_pkg::SEL_STATUS;
      wake_bank_pkg::ADDR_IRQ_MASK:      s = wake_bank_pkg::SEL_MASK;
      wake_bank_pkg::ADDR_WAKE_STATE:    s = wake_bank_pkg::SEL_STATE;
      default:                           s = wake_bank_pkg::SEL_NONE;
    endcase
    return s;
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  wake_bank_pkg::wake_src_t enable_r;          // both enable registers
  wake_bank_pkg::wake_src_t status_in;         // incoming status bits
  wake_bank_pkg::wake_src_t gated;             // enabled and pending
  wake_bank_pkg::apb_rsp_t  rsp_r;             // registered apb answer
  wake_bank_pkg::apb_rsp_t  rsp_nxt;           // next apb answer
  wake_bank_pkg::reg_sel_t  sel;               // decoded register
  logic                     setup;             // apb setup cycle
  logic                     wr_done;           // write takes effect now
  logic                     wake_req;          // combined request, flopped
  logic                     wake_req_d_r;      // request one cycle back
  logic [wake_bank_pkg::RST_PINS_W-1:0] rst_sync;   // synced reset pins
  logic [wake_bank_pkg::RST_PINS_W-1:0] rst_act;    // active-high view
  logic                     rst_act_d_r;       // previous any-reset level
  logic [wake_bank_pkg::EVT_W-1:0] evt;        // event pulses
  logic [wake_bank_pkg::EVT_W-1:0] irq_status_r; // sticky events
  logic [wake_bank_pkg::EVT_W-1:0] irq_mask_r;   // event enables
  logic [wake_bank_pkg::EVT_W-1:0] w1c;        // clear mask from a write

  // grouped SMI status rides bit 3
  assign status_in.grp3 = wake_status_grp3;
  assign status_in.grp4 = wake_status_grp4;
  assign sel            = decode(paddr);
  assign setup          = psel & ~penable;
  assign wr_done        = psel & penable & rsp_r.ready & pwrite;

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------
  // pin resets come from another domain
  sync_two_flop #(
    .WIDTH (wake_bank_pkg::RST_PINS_W)
  ) u_rst_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({hard_reset, soft_reset, ~main_por_n}),
    .sync_out (rst_sync)
  );

  wake_gate #(
    .WIDTH ($bits(wake_bank_pkg::wake_src_t))
  ) u_gate (
    .pclk      (pclk),
    .presetn   (presetn),
    .status    (status_in),
    .enable    (enable_r),
    .global_en (global_wake_enable),
    .gated     (gated),
    .wake_req  (wake_req)
  );

  assign rst_act = rst_sync;

  // ---------------------------------------------------------------
  // enable registers
  // ---------------------------------------------------------------
  // only presetn clears the enables
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable_r.grp3 <= wake_bank_pkg::ENABLE_RESET;
      enable_r.grp4 <= wake_bank_pkg::ENABLE_RESET;
    end else if (wr_done) begin
      // group-3 layout, bit 3 grouped SMI
      if (sel == wake_bank_pkg::SEL_EN3) begin
        enable_r.grp3 <= pwdata[7:0];
      end
      if (sel == wake_bank_pkg::SEL_EN4) begin
        enable_r.grp4 <= pwdata[7:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // apb answer
  // ---------------------------------------------------------------
  // read mux and error, formed in the setup cycle
  always_comb begin
    rsp_nxt        = '0;
    rsp_nxt.ready  = setup;
    if (setup) begin
      case (sel)
        wake_bank_pkg::SEL_EN3: begin
          rsp_nxt.rdata = {24'h00_0000, enable_r.grp3};
        end
        wake_bank_pkg::SEL_EN4: begin
          rsp_nxt.rdata = {24'h00_0000, enable_r.grp4};
        end
        wake_bank_pkg::SEL_STATUS: begin
          rsp_nxt.rdata = {29'h0000_0000, irq_status_r};
        end
        wake_bank_pkg::SEL_MASK: begin
          rsp_nxt.rdata = {29'h0000_0000, irq_mask_r};
        end
        wake_bank_pkg::SEL_STATE: begin
          rsp_nxt.rdata = {16'h0000, gated};
        end
        default: begin
          rsp_nxt.slverr = 1'b1;
        end
      endcase
    end
  end

  // answer registered, one access cycle per transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  assign prdata  = rsp_r.rdata;
  assign pready  = rsp_r.ready;
  assign pslverr = rsp_r.slverr;

  // ---------------------------------------------------------------
  // wake output drive
  // ---------------------------------------------------------------
  // pull the line low while requested
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_request_n_o  <= 1'b1;
      wake_request_n_oe <= 1'b0;
    end else begin
      wake_request_n_o  <= ~wake_req;
      wake_request_n_oe <= wake_req;
    end
  end

  // ---------------------------------------------------------------
  // interrupt events
  // ---------------------------------------------------------------
  // edge history for event pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_req_d_r <= 1'b0;
      rst_act_d_r  <= 1'b0;
    end else begin
      wake_req_d_r <= wake_req;
      rst_act_d_r  <= |rst_act;
    end
  end

  assign evt[wake_bank_pkg::EVT_WAKE_SET]   = wake_req & ~wake_req_d_r;
  assign evt[wake_bank_pkg::EVT_WAKE_CLR]   = ~wake_req & wake_req_d_r;
  assign evt[wake_bank_pkg::EVT_MAIN_RESET] = (|rst_act) & ~rst_act_d_r;
  assign w1c = (wr_done && sel == wake_bank_pkg::SEL_STATUS)
             ? pwdata[wake_bank_pkg::EVT_W-1:0] : '0;

  // sticky status, set wins over write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_r <= wake_bank_pkg::IRQ_RESET;
    end else begin
      irq_status_r <= (irq_status_r & ~w1c) | evt;
    end
  end

  // mask register, plain read/write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask_r <= wake_bank_pkg::IRQ_RESET;
    end else if (wr_done && sel == wake_bank_pkg::SEL_MASK) begin
      irq_mask_r <= pwdata[wake_bank_pkg::EVT_W-1:0];
    end
  end

  // level interrupt, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((irq_status_r & ~w1c) | evt) & irq_mask_r);
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // no drive without a gated source and global gate
  a_wake_needs_gate: assert property (
    wake_request_n_oe |-> $past(global_wake_enable, 2) && ($past(gated, 2) != '0)
  ) else $error("wake driven without enabled pending source");

  // with every enable clear, no source wakes
  a_disabled_no_wake: assert property (
    ($past(enable_r, 2) == '0) |-> !wake_request_n_oe
  ) else $error("wake driven with every enable clear");

  // enables change only through an enable write
  a_enable_hold: assert property (
    (!wr_done || (sel != wake_bank_pkg::SEL_EN3 && sel != wake_bank_pkg::SEL_EN4))
      |=> $stable(enable_r)
  ) else $error("enable register changed without a write");

  // main-side resets leave enables alone
  a_reset_keeps_en: assert property (
    $rose(|rst_act) && !wr_done |=> $stable(enable_r)
  ) else $error("main-side reset disturbed enables");

  // group-3 write lands in the register
  a_grp3_write: assert property (
    wr_done && sel == wake_bank_pkg::SEL_EN3
      |=> enable_r.grp3 == $past(pwdata[7:0])
  ) else $error("group-3 enable write lost");

  // grouped SMI bit alone raises the request
  a_smi_wake: assert property (
    global_wake_enable && enable_r.grp3[wake_bank_pkg::G3_DEVICE_IRQ_BIT]
      && status_in.grp3[wake_bank_pkg::G3_DEVICE_IRQ_BIT] |=> ##1 wake_request_n_oe
  ) else $error("grouped SMI enable did not wake");

  // group-4 write lands
  a_grp4_write: assert property (
    wr_done && sel == wake_bank_pkg::SEL_EN4
      |=> enable_r.grp4 == $past(pwdata[7:0])
  ) else $error("group-4 enable write lost");

  // drive follows the combined condition two cycles on
  a_wake_follow: assert property (
    (global_wake_enable && gated != '0) |-> ##2 (wake_request_n_oe && !wake_request_n_o)
  ) else $error("wake not driven for gated source");

  // released line is not driven
  a_wake_release: assert property (
    !global_wake_enable ##1 !global_wake_enable |=> !wake_request_n_oe
  ) else $error("wake driven with global gate off");

  // answer lasts exactly one access cycle
  a_apb_ready: assert property (
    setup |=> pready ##1 !pready
  ) else $error("apb ready not a single access cycle");

  // read mux returns the group-3 enable
  a_grp3_readback: assert property (
    setup && sel == wake_bank_pkg::SEL_EN3
      |=> prdata == {24'h00_0000, $past(enable_r.grp3)}
  ) else $error("group-3 enable read back wrong");

  // unmapped address answers with an error and no data
  a_unmapped_err: assert property (
    setup && sel == wake_bank_pkg::SEL_NONE |=> pslverr && prdata == '0
  ) else $error("unmapped address not refused");

  // mask write lands
  a_mask_write: assert property (
    wr_done && sel == wake_bank_pkg::SEL_MASK
      |=> irq_mask_r == $past(pwdata[wake_bank_pkg::EVT_W-1:0])
  ) else $error("interrupt mask write lost");

  // an event sets its sticky bit even under a clear
  a_set_wins: assert property (
    evt != '0 |=> (irq_status_r & $past(evt)) == $past(evt)
  ) else $error("event lost against a clear");

  // interrupt level follows unmasked sticky bits
  a_irq_level: assert property (
    $stable(irq_mask_r) |-> irq == (|(irq_status_r & irq_mask_r))
  ) else $error("interrupt level wrong");

  // ---------------------------------------------------------------
  // covers
  // ---------------------------------------------------------------
  c_wake_rise: cover property (
    $rose(wake_request_n_oe)
  );

  c_smi_only: cover property (
    wake_request_n_oe && gated == 16'h0008
  );

  c_irq_clear: cover property (
    irq ##[1:20] !irq
  );

  c_bad_addr: cover property (
    pready && pslverr
  );

  c_set_wins: cover property (
    evt != '0 && w1c != '0
  );

endmodule

//--- testbench/wake_host_model.sv
// host-side model of the open-drain wake line with its pull-up
`timescale 1ns/1ps

module wake_host_model (
  input  wire logic       pclk,              // block clock
  input  wire logic       presetn,           // async reset, active low
  input  wire logic       wake_request_n_o,  // open-drain data
  input  wire logic       wake_request_n_oe, // pull-down enable
  output logic            line_level,        // resolved wire level
  output logic [7:0]      wake_count         // falling edges seen
);
  logic line_prev_r;                         // last sampled level

  // ---------------------------------------------
  // wire resolution
  // ---------------------------------------------
  // released line floats up through the pull-up
  assign line_level = wake_request_n_oe ? wake_request_n_o : 1'b1;

  // counts each new wake request seen by the host
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_prev_r <= 1'b1;
      wake_count  <= 8'h00;
    end else begin
      line_prev_r <= line_level;
      if (line_prev_r && !line_level) begin
        wake_count <= wake_count + 8'h01;
      end
    end
  end
endmodule

//--- testbench/wake_enable_bank_test.sv
// self-checking bench for the wake-enable bank
`timescale 1ns/1ps

module wake_enable_bank_test;
  logic        pclk = 1'b0;                  // 40 MHz clock
  logic        presetn = 1'b0;               // standby reset
  logic        psel = 1'b0;                  // apb select
  logic        penable = 1'b0;               // apb access
  logic        pwrite = 1'b0;                // apb direction
  logic [11:0] paddr = 12'h000;              // apb address
  logic [31:0] pwdata = 32'h0000_0000;       // apb write data
  logic [31:0] prdata;                       // apb read data
  logic        pready;                       // apb ready
  logic        pslverr;                      // apb error
  logic [15:0] src_st = 16'h0000;            // wake status, both groups
  logic        gwe = 1'b0;                   // global gate
  logic [2:0]  rst_pins = 3'b000;            // main, soft, hard active
  logic        wr_o;                         // wake data
  logic        wr_oe;                        // wake enable
  logic        irq;                          // interrupt
  logic        line;                         // resolved wake wire
  logic [7:0]  wake_cnt;                     // host count
  logic [31:0] rd;                           // read result
  logic        er;                           // read error
  logic [15:0] oh;                           // one-hot source
  int          fail_count = 0;               // mismatches
  int          comparisons = 0;              // compares made

  always #12.5 pclk = ~pclk;

  wake_enable_bank DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wake_status_grp3(src_st[7:0]),
    .wake_status_grp4(src_st[15:8]), .global_wake_enable(gwe),
    .main_por_n(!rst_pins[0]), .soft_reset(rst_pins[1]),
    .hard_reset(rst_pins[2]), .wake_request_n_o(wr_o),
    .wake_request_n_oe(wr_oe), .irq(irq)
  );

  wake_host_model host (
    .pclk(pclk), .presetn(presetn), .wake_request_n_o(wr_o),
    .wake_request_n_oe(wr_oe), .line_level(line), .wake_count(wake_cnt)
  );

  // ---------------------------------------------
  // tasks
  // ---------------------------------------------
  // verdict and end of run
  task automatic stop_test;
    if (fail_count == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // one comparison
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // apb transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    repeat (50) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (pready !== 1'b1) begin
      fail_count++;
    end
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // settle time for the two-flop wake path
  task automatic wait3;
    repeat (3) @(posedge pclk);
  endtask

  // watchdog
  initial begin
    #(25ns * 20000);
    fail_count++;
    stop_test();
  end

  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    // reset values and unmapped address
    apb(1'b0, wake_bank_pkg::ADDR_ENABLE_GROUP3, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, wake_bank_pkg::ADDR_ENABLE_GROUP4, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, 12'h100, 32'h0000_0000);
    check({rd[30:0], er}, 32'h0000_0001);
    apb(1'b0, wake_bank_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    // upper bits ignored on write
    apb(1'b1, wake_bank_pkg::ADDR_ENABLE_GROUP3, 32'hffff_ffa5);
    apb(1'b0, wake_bank_pkg::ADDR_ENABLE_GROUP3, 32'h0000_0000);
    check(rd, 32'h0000_00a5);
    // write to an unmapped address is refused and changes nothing
    apb(1'b1, 12'h100, 32'h0000_00ff);
    check({31'h0, er}, 32'h0000_0001);
    apb(1'b0, wake_bank_pkg::ADDR_ENABLE_GROUP3, 32'h0000_0000);
    check(rd, 32'h0000_00a5);
    // each source alone: bit i of 3 then 4, bit 3 the grouped SMI
    for (int i = 0; i < 16; i++) begin
      oh = 16'h0001 << i;
      apb(1'b1, wake_bank_pkg::ADDR_ENABLE_GROUP3, {24'h00_0000, oh[7:0]});
      apb(1'b1, wake_bank_pkg::ADDR_ENABLE_GROUP4, {24'h00_0000, oh[15:8]});
      src_st <= ~oh;
      gwe    <= 1'b1;
      wait3();
      check({31'h0, line}, 32'h0000_0001);
      apb(1'b0, wake_bank_pkg::ADDR_WAKE_STATE, 32'h0000_0000);
      check(rd, 32'h0000_0000);
      src_st <= 16'hffff;
      wait3();
      check({31'h0, line}, 32'h0000_0000);
      apb(1'b0, wake_bank_pkg::ADDR_WAKE_STATE, 32'h0000_0000);
      check(rd, {16'h0000, oh});
      gwe <= 1'b0;
      wait3();
      check({31'h0, line}, 32'h0000_0001);
    end
    check({24'h00_0000, wake_cnt}, 32'h0000_0010);
    // sticky events, masked then unmasked, then cleared
    apb(1'b0, wake_bank_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
    check(rd, 32'h0000_0003);
    check({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, wake_bank_pkg::ADDR_IRQ_MASK, 32'h0000_0007);
    wait3();
    check({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, wake_bank_pkg::ADDR_IRQ_STATUS, 32'h0000_0003);
    wait3();
    check({31'h0, irq}, 32'h0000_0000);
    // main, soft and hard reset leave enables alone, raise an event
    for (int p = 0; p < 3; p++) begin
      rst_pins[p] <= 1'b1;
      repeat (4) @(posedge pclk);
      rst_pins[p] <= 1'b0;
      wait3();
      check({31'h0, irq}, 32'h0000_0001);
      apb(1'b0, wake_bank_pkg::ADDR_IRQ_STATUS, 32'h0000_0000);
      check(rd, 32'h0000_0004);
      apb(1'b1, wake_bank_pkg::ADDR_IRQ_STATUS, 32'h0000_0004);
      apb(1'b0, wake_bank_pkg::ADDR_ENABLE_GROUP4, 32'h0000_0000);
      check(rd, 32'h0000_0080);
    end
    // standby reset in mid-run clears the enables
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, wake_bank_pkg::ADDR_ENABLE_GROUP4, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    stop_test();
  end
endmodule
